// File: sebs_pkg.sv
// shared constants and types for the serial eeprom bus slave link
`default_nettype none
package sebs_pkg;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int unsigned MCLK_MHZ    = 100;
  localparam int unsigned WC_TIME_MS  = 5;
  localparam int unsigned WC_CYC_DFLT = WC_TIME_MS * MCLK_MHZ * 1000;
  localparam int unsigned HOLD_NS     = 300;
  localparam int unsigned HOLD_CYC    = (HOLD_NS * MCLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_W      = $clog2(HOLD_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LD  = HOLD_W'(HOLD_CYC);
  localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);
  localparam int unsigned SCL_KHZ     = 100;
  localparam int unsigned QTR_CYC     =
    (MCLK_MHZ * 1000 + SCL_KHZ * 4 - 1) / (SCL_KHZ * 4);

  // ---------------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5; // arbitrary value
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [5:0] STEP_LAST_CND = 6'h03;
  localparam logic [5:0] STEP_LAST_BYT = 6'h23;
  localparam logic [1:0] PH_SET  = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_MID  = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // sampled pin vector positions in the device
  localparam int unsigned PIN_W   = 6;
  localparam int unsigned P_SCL   = 0;
  localparam int unsigned P_SDA   = 1;
  localparam int unsigned P_CS_LO = 2;
  localparam int unsigned P_CS_MI = 3;
  localparam int unsigned P_CS_HI = 4;
  localparam int unsigned P_WP    = 5;

  typedef enum logic [1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } sebs_cmd_t;
endpackage
`default_nettype wire

// File: sebs_link_if.sv
// two-wire link between bus master and eeprom slave front end
`default_nettype none
interface sebs_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;

  // open-drain wired-and with pull-up: any enabled low wins
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport dev_mp (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe
  );
  modport host_mp (
    output scl,
    output sda_host_o,
    output sda_host_oe,
    input  sda
  );
endinterface
`default_nettype wire

// File: sebs_sync.sv
// two-flop synchroniser with a registered previous value for edges
`default_nettype none
module sebs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q,
  output var  logic [W-1:0] q_prev
);
  logic [W-1:0] meta_q;

  // meta_q feeds only q; edge logic looks at q and q_prev
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '1;
      q      <= '1;
      q_prev <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
      q_prev <= q;
    end
  end
endmodule // sebs_sync
`default_nettype wire

// File: sebs_dev.sv
// slave end: start/stop detect, addressing, ack and byte shifting
`default_nettype none
module sebs_dev #(
  parameter int unsigned WC_CYC       = sebs_pkg::WC_CYC_DFLT,
  parameter bit          REDUCED_PINS = 1'b0
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  sebs_link_if.dev_mp     link,
  input  wire logic       chip_sel_bit_low,
  input  wire logic       chip_sel_bit_mid,
  input  wire logic       chip_sel_bit_high,
  input  wire logic       write_protect,
  input  wire logic [7:0] tx_data,
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  output var  logic       tx_next,
  output var  logic       wr_commit,
  output var  logic       wr_busy
);
  import sebs_pkg::*;

  localparam int unsigned WC_W = $clog2(WC_CYC + 1);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_WAIT
  } sebs_dstate_t;

  // ---------------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic [PIN_W-1:0] pin_p;

  assign pin_raw = {write_protect, chip_sel_bit_high, chip_sel_bit_mid,
                    chip_sel_bit_low, link.sda, link.scl};

  // every pin crosses into mclk before use
  sebs_sync #(
    .W (PIN_W)
  ) u_sync (
    .mclk   (mclk),
    .nrst   (nrst),
    .d      (pin_raw),
    .q      (pin_s),
    .q_prev (pin_p)
  );

  // ---------------------------------------------------------------------
  // line events and address match
  // ---------------------------------------------------------------------
  wire       scl_s    = pin_s[P_SCL];
  wire       scl_p    = pin_p[P_SCL];
  wire       sda_s    = pin_s[P_SDA];
  wire       sda_p    = pin_p[P_SDA];
  wire       wp_s     = pin_s[P_WP];
  wire       scl_rise = scl_s & ~scl_p;
  wire       scl_fall = ~scl_s & scl_p;
  wire       scl_hold = scl_s & scl_p;
  wire       start_ev = scl_hold & sda_p & ~sda_s;
  wire       stop_ev  = scl_hold & ~sda_p & sda_s;
  // missing low selects compare as zero on the reduced-pin part
  wire [2:0] cs_pins  = REDUCED_PINS ? {pin_s[P_CS_HI], 2'h0} :
                        {pin_s[P_CS_HI], pin_s[P_CS_MI], pin_s[P_CS_LO]};

  sebs_dstate_t    state_q, state_d;
  logic [3:0]      bcnt_q, bcnt_d;
  logic [7:0]      shift_q, shift_d;
  logic [7:0]      rxd_d;
  logic            read_q, read_d;
  logic            wrp_q, wrp_d;
  logic            rxv_d, txn_d, commit_d;
  logic            sched, sched_lo, rel_now;
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic            pend_q, pend_d;
  logic            sda_oe_q, oe_d;
  logic            sda_o_q;
  logic [WC_W-1:0] wc_q, wc_d;

  wire busy     = (wc_q != '0);
  // type code, selects and idle programming engine must all agree
  wire ctrl_hit = (shift_q[7:4] == DEV_TYPE_CODE)
                & (shift_q[3:1] == cs_pins)
                & ~busy;

  // ---------------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------------
  // start and stop override everything; they may come at any bit
  always_comb begin
    state_d  = state_q;
    bcnt_d   = bcnt_q;
    shift_d  = shift_q;
    read_d   = read_q;
    wrp_d    = wrp_q;
    rxd_d    = rx_data;
    rxv_d    = 1'h0;
    txn_d    = 1'h0;
    commit_d = 1'h0;
    sched    = 1'h0;
    sched_lo = 1'h0;
    rel_now  = 1'h0;
    if (start_ev) begin
      state_d = ST_CTRL;
      bcnt_d  = '0;
      read_d  = 1'h0;
      wrp_d   = 1'h0;
      rel_now = 1'h1;
    end else if (stop_ev) begin
      state_d  = ST_IDLE;
      wrp_d    = 1'h0;
      rel_now  = 1'h1;
      commit_d = wrp_q & ~wp_s & ~busy;
    end else begin
      case (state_q)
        ST_CTRL, ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bcnt_d  = bcnt_q + 4'h1;
          end else if (scl_fall && bcnt_q == BYTE_BITS) begin
            bcnt_d = '0;
            if (state_q == ST_RX) begin
              rxd_d    = shift_q;
              rxv_d    = 1'h1;
              wrp_d    = 1'h1;
              state_d  = ST_ACK;
              sched    = 1'h1;
              sched_lo = 1'h1;
            end else if (ctrl_hit) begin
              state_d  = ST_ACK;
              sched    = 1'h1;
              sched_lo = 1'h1;
              read_d   = shift_q[0];
              txn_d    = shift_q[0];
            end else begin
              state_d  = ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bcnt_d = '0;
            sched  = 1'h1;
            if (read_q) begin
              state_d  = ST_TX;
              shift_d  = tx_data;
              sched_lo = ~tx_data[7];
            end else begin
              state_d  = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bcnt_d = bcnt_q + 4'h1;
          end else if (scl_fall) begin
            sched = 1'h1;
            if (bcnt_q == BYTE_BITS) begin
              state_d = ST_TXACK;
              bcnt_d  = '0;
            end else begin
              shift_d  = {shift_q[6:0], 1'h0};
              sched_lo = ~shift_q[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_d = ST_WAIT;
            end else begin
              state_d = ST_ACK;
              txn_d   = 1'h1;
            end
          end
        end
        ST_IDLE, ST_WAIT: begin
          state_d = state_q;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // delayed data drive and write cycle timer
  // ---------------------------------------------------------------------
  // a change is applied HOLD_CYC after the clock fall, so the line
  // never moves near a clock edge and fakes a start or stop
  assign hold_d = rel_now ? '0 :
                  sched ? HOLD_LD :
                  (hold_q != '0) ? hold_q - HOLD_ONE : hold_q;
  assign pend_d = sched ? sched_lo : pend_q;
  assign oe_d   = rel_now ? 1'h0 :
                  (hold_q == HOLD_ONE) ? pend_q : sda_oe_q;
  // the engine counts the full worst-case time; no early finish
  assign wc_d   = commit_d ? WC_W'(WC_CYC) :
                  busy ? wc_q - WC_W'(1) : wc_q;

  // state and counters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      bcnt_q  <= '0;
      shift_q <= '0;
      read_q  <= 1'h0;
      wrp_q   <= 1'h0;
      hold_q  <= '0;
      pend_q  <= 1'h0;
      wc_q    <= '0;
    end else begin
      state_q <= state_d;
      bcnt_q  <= bcnt_d;
      shift_q <= shift_d;
      read_q  <= read_d;
      wrp_q   <= wrp_d;
      hold_q  <= hold_d;
      pend_q  <= pend_d;
      wc_q    <= wc_d;
    end
  end

  // registered outputs; the data pin is never driven high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sda_oe_q  <= 1'h0;
      sda_o_q   <= 1'h0;
      rx_data   <= '0;
      rx_valid  <= 1'h0;
      tx_next   <= 1'h0;
      wr_commit <= 1'h0;
      wr_busy   <= 1'h0;
    end else begin
      sda_oe_q  <= oe_d;
      sda_o_q   <= 1'h0;
      rx_data   <= rxd_d;
      rx_valid  <= rxv_d;
      tx_next   <= txn_d;
      wr_commit <= commit_d;
      wr_busy   <= (wc_d != '0);
    end
  end

  assign link.sda_dev_oe = sda_oe_q;
  assign link.sda_dev_o  = sda_o_q;
endmodule // sebs_dev
`default_nettype wire

// File: sebs_host.sv
// master end: clock divider and start, stop, byte write, byte read
`default_nettype none
module sebs_host #(
  parameter int unsigned QTR = sebs_pkg::QTR_CYC
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  sebs_link_if.host_mp           link,
  input  wire logic              cmd_valid,
  input  wire sebs_pkg::sebs_cmd_t cmd_op,
  input  wire logic [7:0]        cmd_byte,
  input  wire logic              cmd_nack,
  output var  logic              cmd_ready,
  output var  logic              done,
  output var  logic [7:0]        rd_data,
  output var  logic              ack_seen
);
  import sebs_pkg::*;

  localparam int unsigned DIV_W = $clog2(QTR);

  typedef enum logic {
    HS_IDLE,
    HS_RUN
  } sebs_hstate_t;

  sebs_hstate_t     state_q, state_d;
  sebs_cmd_t        op_q, op_d;
  logic [DIV_W-1:0] div_q;
  logic [5:0]       step_q, step_d;
  logic [8:0]       txs_q, txs_d;
  logic [8:0]       rxs_q, rxs_d;
  logic             scl_q, scl_d;
  logic             oe_q, oe_d;
  logic             sda_o_q;
  logic             done_d;
  logic [7:0]       rd_d;
  logic             ack_d;
  logic             sda_s;

  // returning data comes from another party's logic
  sebs_sync #(
    .W (1)
  ) u_sync (
    .mclk   (mclk),
    .nrst   (nrst),
    .d      (link.sda),
    .q      (sda_s),
    .q_prev ()
  );

  // ---------------------------------------------------------------------
  // quarter-bit timing and step decode
  // ---------------------------------------------------------------------
  wire       qtick   = (div_q == '0);
  wire [1:0] ph      = step_q[1:0];
  wire       is_cond = (op_q == CMD_START) || (op_q == CMD_STOP);
  wire [5:0] last    = is_cond ? STEP_LAST_CND : STEP_LAST_BYT;

  // free-running divider; each step action waits one quarter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
    end else begin
      div_q <= qtick ? DIV_W'(QTR - 1) : div_q - DIV_W'(1);
    end
  end

  // ---------------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------------
  // a byte is nine bits: eight data then the acknowledge slot
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    step_d  = step_q;
    txs_d   = txs_q;
    rxs_d   = rxs_q;
    scl_d   = scl_q;
    oe_d    = oe_q;
    done_d  = 1'h0;
    rd_d    = rd_data;
    ack_d   = ack_seen;
    case (state_q)
      HS_IDLE: begin
        if (cmd_valid) begin
          state_d = HS_RUN;
          op_d    = cmd_op;
          step_d  = '0;
          // read: release data bits, drive our ack or nack
          txs_d   = (cmd_op == CMD_READ) ? {8'hff, cmd_nack} :
                    {cmd_byte, 1'h1};
        end
      end
      HS_RUN: begin
        if (qtick) begin
          step_d = step_q + 6'h01;
          case (op_q)
            CMD_START: begin
              // release, clock high, data low while high
              if (ph == PH_SET)  oe_d  = 1'h0;
              if (ph == PH_RISE) scl_d = 1'h1;
              if (ph == PH_MID)  oe_d  = 1'h1;
              if (ph == PH_FALL) scl_d = 1'h0;
            end
            CMD_STOP: begin
              if (ph == PH_SET)  oe_d  = 1'h1;
              if (ph == PH_RISE) scl_d = 1'h1;
              if (ph == PH_MID)  oe_d  = 1'h0;
            end
            default: begin
              // data set only while the clock is low
              if (ph == PH_SET)  oe_d  = ~txs_q[8];
              if (ph == PH_RISE) scl_d = 1'h1;
              if (ph == PH_MID)  rxs_d = {rxs_q[7:0], sda_s};
              if (ph == PH_FALL) begin
                scl_d = 1'h0;
                txs_d = {txs_q[7:0], 1'h0};
              end
            end
          endcase
          if (step_q == last) begin
            state_d = HS_IDLE;
            done_d  = 1'h1;
            if (!is_cond) begin
              rd_d  = rxs_d[8:1];
              ack_d = ~rxs_d[0];
            end
          end
        end
      end
      default: begin
        state_d = HS_IDLE;
      end
    endcase
  end

  // sequencer registers; idle bus is clock and data high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= HS_IDLE;
      op_q      <= CMD_STOP;
      step_q    <= '0;
      txs_q     <= '0;
      rxs_q     <= '0;
      scl_q     <= 1'h1;
      oe_q      <= 1'h0;
      sda_o_q   <= 1'h0;
      cmd_ready <= 1'h1;
      done      <= 1'h0;
      rd_data   <= '0;
      ack_seen  <= 1'h0;
    end else begin
      state_q   <= state_d;
      op_q      <= op_d;
      step_q    <= step_d;
      txs_q     <= txs_d;
      rxs_q     <= rxs_d;
      scl_q     <= scl_d;
      oe_q      <= oe_d;
      sda_o_q   <= 1'h0;
      cmd_ready <= (state_d == HS_IDLE);
      done      <= done_d;
      rd_data   <= rd_d;
      ack_seen  <= ack_d;
    end
  end

  assign link.scl         = scl_q;
  assign link.sda_host_oe = oe_q;
  assign link.sda_host_o  = sda_o_q;
endmodule // sebs_host
`default_nettype wire

// File: sebs_link_props.sv
// concurrent checks on the two-wire link between host and slave ends
`default_nettype none
module sebs_link_props #(
  parameter int unsigned QTR = 50
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  import sebs_pkg::*;

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------------
  logic [15:0] hi_cnt_q;
  logic [15:0] lo_cnt_q;

  // run length of each clock level; saturating so a long idle cannot wrap
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_q <= 16'h0000;
      lo_cnt_q <= 16'h0000;
    end else begin
      hi_cnt_q <= scl ? hi_cnt_q + {15'h0000, ~&hi_cnt_q} : 16'h0000;
      lo_cnt_q <= scl ? 16'h0000 : lo_cnt_q + {15'h0000, ~&lo_cnt_q};
    end
  end

  // ---------------------------------------------------------------------
  // bus conditions
  // ---------------------------------------------------------------------
  sequence start_ev;
    scl && $past(scl) && $past(sda) && !sda;
  endsequence
  sequence stop_ev;
    scl && $past(scl) && !$past(sda) && sda;
  endsequence

  // open drain: a driver only ever pulls low
  dev_drive_low_a: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives data line high");
  host_drive_low_a: assert property (sda_host_oe |-> !sda_host_o)
    else $error("host drives data line high");
  // device changes data only in the low phase, after the hold delay
  dev_edge_low_a: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("device pulls data while clock high");
  dev_hold_time_a: assert property (
    $changed(sda_dev_oe) && !scl |-> lo_cnt_q >= HOLD_CYC)
    else $error("device data change too soon after clock fall");
  dev_stable_high_a: assert property (
    scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device data moved during clock high");
  host_setup_a: assert property (
    $changed(sda_host_oe) && !scl |-> lo_cnt_q >= QTR - 1)
    else $error("host data change too close to clock fall");
  start_by_host_a: assert property (
    start_ev |-> sda_host_oe && !sda_dev_oe)
    else $error("start not made by host alone");
  stop_released_a: assert property (stop_ev |-> !sda_dev_oe [*4])
    else $error("device holds data line after stop");
  scl_high_time_a: assert property (
    $fell(scl) |-> hi_cnt_q >= 2 * QTR - 1)
    else $error("clock high phase short");
  scl_low_time_a: assert property (
    $rose(scl) |-> lo_cnt_q >= 2 * QTR - 1)
    else $error("clock low phase short");
  dev_pull_bound_a: assert property (
    $rose(sda_dev_oe) |-> ##[1:1000] !sda_dev_oe)
    else $error("device never releases data line");
endmodule // sebs_link_props
`default_nettype wire

// File: serial_eeprom_bus_slave_tb.sv
// self-checking bench joining host and slave ends over the link
`default_nettype none
module serial_eeprom_bus_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sebs_pkg::*;

  // short quarter bit and write cycle keep the run brief
  localparam int unsigned QTR = 50;
  localparam int unsigned WC  = 4000;

  logic       mclk      = 1'b0;
  logic       nrst      = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_nack  = 1'b0;
  logic       wp        = 1'b0;
  sebs_cmd_t  cmd_op    = CMD_START;
  logic [7:0] cmd_byte  = 8'h00;
  logic [7:0] tx_data   = 8'h5a;
  logic [7:0] last_rx   = 8'h00;
  logic [2:0] cs_lvl    = 3'h5;
  logic [7:0] rp_rx;
  logic       rp_busy;
  logic       cmd_ready;
  logic       done;
  logic       ack_seen;
  logic [7:0] rd_data;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       tx_next;
  logic       wr_commit;
  logic       wr_busy;
  int         err_count = 0;
  int         n_tests   = 0;
  int         cm_cnt    = 0;

  always #5 mclk = ~mclk;

  sebs_link_if sebs_link_if_i ();
  sebs_host #(.QTR(QTR)) sebs_host_i (
    .mclk(mclk), .nrst(nrst), .link(sebs_link_if_i),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_byte(cmd_byte),
    .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .done(done),
    .rd_data(rd_data), .ack_seen(ack_seen));
  // chip selects hold a defined level from time zero, before reset ends
  sebs_dev #(.WC_CYC(WC)) sebs_dev_i (
    .mclk(mclk), .nrst(nrst), .link(sebs_link_if_i),
    .chip_sel_bit_low(cs_lvl[0]), .chip_sel_bit_mid(cs_lvl[1]),
    .chip_sel_bit_high(cs_lvl[2]), .write_protect(wp), .tx_data(tx_data),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_next(tx_next),
    .wr_commit(wr_commit), .wr_busy(wr_busy));
  // reduced-pin slave hears the shared bus through a second carrier;
  // its acks stay there, so its own outputs are what gets checked
  sebs_link_if sebs_link_rp_i ();
  assign sebs_link_rp_i.scl         = sebs_link_if_i.scl;
  assign sebs_link_rp_i.sda_host_o  = 1'b0;
  assign sebs_link_rp_i.sda_host_oe = ~sebs_link_if_i.sda;
  sebs_dev #(.WC_CYC(WC), .REDUCED_PINS(1'b1)) sebs_dev_rp_i (
    .mclk(mclk), .nrst(nrst), .link(sebs_link_rp_i),
    .chip_sel_bit_low(cs_lvl[0]), .chip_sel_bit_mid(cs_lvl[1]),
    .chip_sel_bit_high(cs_lvl[2]), .write_protect(1'b0),
    .tx_data(8'h00), .rx_data(rp_rx), .rx_valid(), .tx_next(),
    .wr_commit(), .wr_busy(rp_busy));
  sebs_link_props #(.QTR(QTR)) sebs_link_props_i (
    .mclk(mclk), .nrst(nrst), .scl(sebs_link_if_i.scl),
    .sda_host_o(sebs_link_if_i.sda_host_o),
    .sda_host_oe(sebs_link_if_i.sda_host_oe),
    .sda_dev_o(sebs_link_if_i.sda_dev_o),
    .sda_dev_oe(sebs_link_if_i.sda_dev_oe), .sda(sebs_link_if_i.sda));

  // ---------------------------------------------------------------------
  // user side of the device
  // ---------------------------------------------------------------------
  // a new byte per request, so each read byte is distinct
  always @(posedge mclk) begin
    if (tx_next === 1'b1) begin
      #1;
      tx_data = tx_data + 8'h01;
    end
  end
  // latch received bytes and count commit pulses
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) last_rx = rx_data;
    if (wr_commit === 1'b1) cm_cnt++;
  end

  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one host command; a stuck handshake ends the run
  task automatic do_cmd(input sebs_cmd_t op, input logic [7:0] b,
                        input logic nk);
    int i;
    for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) tick();
    if (i == 60) begin
      chk(1'b0, "host never ready");
      report_and_stop();
    end
    cmd_op = op;
    cmd_byte = b;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    for (i = 0; i < 2500 && done !== 1'b1; i++) tick();
    if (i == 2500) begin
      chk(1'b0, "command never done");
      report_and_stop();
    end
  endtask

  // byte write; the host echoes the line bits it sampled
  task automatic wr(input logic [7:0] b, input logic ack);
    do_cmd(CMD_WRITE, b, 1'b0);
    chk(ack_seen === ack, "acknowledge");
    chk(rd_data === b, "line bits");
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_write();
    int i;
    int c0;
    c0 = cm_cnt;
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
    wr(8'ha6, 1'b1);
    chk(last_rx === 8'ha6, "received byte");
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    for (i = 0; i < 20 && cm_cnt == c0; i++) tick();
    chk(cm_cnt == c0 + 1 && wr_busy === 1'b1, "write start");
    if (i == 20) report_and_stop();
  endtask

  // polling while busy gets no ack; acks come back once the cycle ends
  task automatic t_busy();
    int i;
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b0);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    for (i = 0; i < WC && wr_busy === 1'b1; i++) tick();
    chk(wr_busy === 1'b0, "write cycle too long");
    if (i == WC) report_and_stop();
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
  endtask

  // a repeated start drops the pending write
  task automatic t_restart();
    int c0;
    c0 = cm_cnt;
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
    wr(8'h81, 1'b1);
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    repeat (20) tick();
    chk(cm_cnt == c0, "commit after restart");
  endtask

  // each select bit wrong in turn, then a wrong type code
  task automatic t_mismatch();
    logic [7:0] bad [4] = '{{DEV_TYPE_CODE, 3'h4, 1'b0},
                            {DEV_TYPE_CODE, 3'h7, 1'b0},
                            {DEV_TYPE_CODE, 3'h1, 1'b1},
                            {4'h6, 3'h5, 1'b0}};
    for (int k = 0; k < 4; k++) begin
      do_cmd(CMD_START, 8'h00, 1'b0);
      wr(bad[k], 1'b0);
      do_cmd(CMD_STOP, 8'h00, 1'b0);
    end
  endtask

  // protected write is acked but never committed
  task automatic t_wp();
    int c0;
    c0 = cm_cnt;
    wp = 1'b1;
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h5, 1'b0}, 1'b1);
    wr(8'h3c, 1'b1);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    repeat (20) tick();
    chk(cm_cnt == c0 && wr_busy === 1'b0, "protected write");
  endtask

  // two-byte read with protection still on, ended by a withheld ack
  task automatic t_read();
    logic [7:0] t0;
    t0 = tx_data;
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h5, 1'b1}, 1'b1);
    do_cmd(CMD_READ, 8'h00, 1'b0);
    chk(rd_data === t0 + 8'h01, "first read byte");
    do_cmd(CMD_READ, 8'h00, 1'b1);
    chk(rd_data === t0 + 8'h02, "last read byte");
    repeat (2 * QTR) tick();
    chk(sebs_link_if_i.sda === 1'b1, "line not released");
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    wp = 1'b0;
  endtask

  // the reduced-pin slave compares the two low select bits against zero
  task automatic t_reduced();
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h7, 1'b0}, 1'b0);
    wr(8'h22, 1'b0);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    chk(rp_busy === 1'b0, "low selects compared");
    do_cmd(CMD_START, 8'h00, 1'b0);
    wr({DEV_TYPE_CODE, 3'h4, 1'b0}, 1'b0);
    wr(8'h11, 1'b0);
    do_cmd(CMD_STOP, 8'h00, 1'b0);
    chk(rp_busy === 1'b1 && rp_rx === 8'h11, "reduced write");
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    repeat (4) tick();
    t_write();
    t_busy();
    t_restart();
    t_mismatch();
    t_wp();
    t_read();
    t_reduced();
    report_and_stop();
  end
endmodule // serial_eeprom_bus_slave_tb
`default_nettype wire
